// *** hw/mras_defines.vh ***
// constants for the serial management register access slave
// assumes inclusion by the slave design file only; definitions only
`ifndef MRAS_DEFINES_VH
`define MRAS_DEFINES_VH

`define MRAS_PRE_LEN      6'd32   // preamble ones required
`define MRAS_ST_PAT       2'b01   // start of frame pattern
`define MRAS_OP_EXT       2'b00   // extended config access
`define MRAS_OP_WR        2'b01   // standard write
`define MRAS_OP_RD        2'b10   // standard read
`define MRAS_TA_WR        2'b10   // write turnaround bits
`define MRAS_HDR_BITS     5'd14   // st+op+phy+reg bits
`define MRAS_DATA_BITS    5'd16   // data field length
`define MRAS_EXT_LAST     8'hc6   // highest extended address
`define MRAS_EXT_DEPTH    9'd199  // extended register count
`define MRAS_PHY_R0       5'h00   // first standard register
`define MRAS_PHY_R5       5'h05   // last standard register
`define MRAS_PHY_R29      5'h1d   // vendor register a
`define MRAS_PHY_R31      5'h1f   // vendor register b
`define MRAS_IND_BASE     8'hd0   // indirect window base
`define MRAS_IND_MASK     8'hf0   // indirect window is one nibble
`define MRAS_MDC_MAX_KHZ  32'd5000 // management clock limit

`endif

// *** hw/mras_slave.v ***
// serial management slave: standard and extended register frames
// assumes mdc/mdio pins asynchronous to mclk, mclk far faster than mdc
// assumes mdc stands high and mdio is pulled high between frames
// What this block does
// - works with management clock up to 5 MHz
// - frame: preamble, start, op, addresses, turnaround, data
// - opcode 10 reads, 01 writes standard registers
// - eight standard registers: 0..5, 29, 31
// - opcode 00 with address bit4 set reads extended
// - opcode 00 with address bit4 clear writes extended
// - address bit3 ignored in extended frames
// - extended address is phy[2:0] then reg[4:0]
// - extended registers 0x00 to 0xc6 all reachable
// - read turnaround: release, then drive zero
// - extended read of config space returns zero upper byte
// - extended write to config space stores only low byte
// - extended frames also reach standard registers
// - extended frames share standard framing conventions
`include "mras_defines.vh"
`default_nettype none
module mras_slave #(
    parameter PHY_ADDR = 5'h01   // standard frame phy address, arbitrary
) (
    input  wire mclk,
    input  wire rst_b,
    input  wire mdc,
    input  wire mdio_in,
    output reg  mdio_out,
    output reg  mdio_oe_b,
    output reg  busy
);
    // frame states, one for each stretch of the frame
    localparam S_PRE  = 3'd0;  // counting preamble ones
    localparam S_HDR  = 3'd1;  // start, op, addresses
    localparam S_TA   = 3'd2;  // turnaround
    localparam S_RD   = 3'd3;  // shifting read data out
    localparam S_WR   = 3'd4;  // shifting write data in
    localparam S_IDLE = 3'd5;  // ignore rest of frame

    // mdc is never used as a clock: its rising edge becomes an enable
    // pulse of mclk, so the whole slave stays in one clock domain
    wire       mdc_rise;       // one-cycle rising edge enable
    wire       mdio_s;         // synced data
    reg [2:0]  state;          // frame state
    reg [5:0]  cnt;            // bit counter
    reg [13:0] hdr;            // st,op,phy,reg shifted in
    reg [15:0] sh;             // data shift register
    reg        ta_first;       // first turnaround bit seen
    // plain storage; no register has side effects on read or write
    reg [15:0] phy_reg [0:7];  // standard register file
    reg [7:0]  ext_reg [0:`MRAS_EXT_DEPTH-1]; // extended register file
    integer    i;              // reset loop index

    // sample pins through three flops each; only the clock's edge and the
    // data's level are needed, the other outputs stay open
    mras_sync u_mdc (.mclk(mclk), .rst_b(rst_b), .din(mdc),
                     .dout(), .rise(mdc_rise));
    mras_sync u_mdio (.mclk(mclk), .rst_b(rst_b), .din(mdio_in),
                      .dout(mdio_s), .rise());

    // map standard address to table slot, 4'hf when unmapped
    function [3:0] mras_phy_slot;
        input [4:0] ra;
        begin
            if (ra <= `MRAS_PHY_R5)
                mras_phy_slot = {1'b0, ra[2:0]};
            else if (ra == `MRAS_PHY_R29)
                mras_phy_slot = 4'h6;
            else if (ra == `MRAS_PHY_R31)
                mras_phy_slot = 4'h7;
            else
                mras_phy_slot = 4'hf;
        end
    endfunction

    wire [1:0] op      = hdr[11:10];
    wire [4:0] phy     = hdr[9:5];
    wire [4:0] rad     = hdr[4:0];
    wire [7:0] ext_ad  = {phy[2:0], rad};
    wire       is_ext  = (op == `MRAS_OP_EXT);
    wire       ext_rd  = is_ext & phy[4];
    wire       ext_wr  = is_ext & ~phy[4];
    wire       ext_ok  = ext_ad <= `MRAS_EXT_LAST;
    // indirect window above the config space carries phy registers:
    // 0xd0-0xd5 reach registers 0-5, 0xdd and 0xdf the vendor pair;
    // the window is one nibble wide so 0xe0 and up stay unmapped
    wire       ind_hit = (ext_ad & `MRAS_IND_MASK) == `MRAS_IND_BASE;
    // low nibble d and f become 29 and 31 by repeating bit 3 above it
    wire [3:0] ind_sl  = mras_phy_slot({ext_ad[3], ext_ad[3:0]});
    wire [3:0] std_sl  = mras_phy_slot(rad);
    wire       std_hit = (phy == PHY_ADDR) & (std_sl != 4'hf);
    // only a read meant for this device may drive the shared line;
    // a standard read for another address is left to its owner
    wire       rd_drive = ((op == `MRAS_OP_RD) & (phy == PHY_ADDR)) | ext_rd;

    // read data chosen at turnaround
    // unmapped addresses give zero rather than stale data
    reg [15:0] next_rdata;
    always @* begin
        next_rdata = 16'h0000;
        if (ext_rd) begin
            if (ind_hit && ind_sl != 4'hf)
                next_rdata = phy_reg[ind_sl[2:0]];
            else if (ext_ok)
                next_rdata = {8'h00, ext_reg[ext_ad]};
        end else if (std_hit)
            next_rdata = phy_reg[std_sl[2:0]];
    end

    // frame engine, advanced only on mdc rising edges
    // a bit is seen three mclk after the pin edge, so read data changes
    // soon after that rising edge, in its high half, and is settled long before
    // the controller's next rising edge; this is why mclk must run many
    // times faster than the management clock
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= S_PRE;
            cnt       <= 6'd0;
            hdr       <= 14'h0000;
            sh        <= 16'h0000;
            ta_first  <= 1'b0;
            mdio_out  <= 1'b1;
            mdio_oe_b <= 1'b1;
            busy      <= 1'b0;
            for (i = 0; i < 8; i = i + 1)
                phy_reg[i] <= 16'h0000;
            for (i = 0; i < `MRAS_EXT_DEPTH; i = i + 1)
                ext_reg[i] <= 8'h00;
        end else if (mdc_rise) begin
            case (state)
                S_PRE: begin
                    // count saturates, so a long idle high also counts
                    busy <= 1'b0;
                    if (!mdio_s) begin
                        // zero after full preamble is start bit 0
                        if (cnt >= `MRAS_PRE_LEN) begin
                            state <= S_HDR;
                            hdr   <= 14'h0000;
                            cnt   <= 6'd1;
                            busy  <= 1'b1;
                        end else
                            cnt <= 6'd0;
                    end else if (cnt < `MRAS_PRE_LEN)
                        cnt <= cnt + 6'd1;
                end
                S_HDR: begin
                    // start bit 1, opcode, phy and reg bits, msb first
                    hdr <= {hdr[12:0], mdio_s};
                    cnt <= cnt + 6'd1;
                    if (cnt == {1'b0, `MRAS_HDR_BITS} - 6'd1) begin
                        state    <= S_TA;
                        ta_first <= 1'b0;
                    end
                end
                S_TA: begin
                    ta_first <= 1'b1;
                    cnt      <= 6'd0;
                    if (hdr[13:12] != `MRAS_ST_PAT)
                        state <= S_IDLE;             // bad start
                    else if (!ta_first) begin
                        // controller released; drive zero next
                        if (rd_drive) begin
                            mdio_out  <= 1'b0;
                            mdio_oe_b <= 1'b0;
                            sh        <= next_rdata;
                        end
                    end else if (!mdio_oe_b) begin
                        state    <= S_RD;
                        mdio_out <= sh[15];
                        sh       <= {sh[14:0], 1'b0};
                    end else if (op == `MRAS_OP_WR || ext_wr)
                        state <= S_WR;               // assumed
                    else
                        state <= S_IDLE;
                end
                S_RD: begin
                    cnt <= cnt + 6'd1;
                    if (cnt == {1'b0, `MRAS_DATA_BITS} - 6'd1) begin
                        mdio_oe_b <= 1'b1;           // back to z
                        mdio_out  <= 1'b1;
                        state     <= S_PRE;
                        busy      <= 1'b0;
                        // next frame needs a full preamble of its own
                        cnt       <= 6'd0;
                    end else begin
                        mdio_out <= sh[15];
                        sh       <= {sh[14:0], 1'b0};
                    end
                end
                S_WR: begin
                    sh  <= {sh[14:0], mdio_s};
                    cnt <= cnt + 6'd1;
                    if (cnt == {1'b0, `MRAS_DATA_BITS} - 6'd1) begin
                        state <= S_PRE;
                        busy  <= 1'b0;
                        cnt   <= 6'd0;               // fresh preamble count
                        if (ext_wr) begin
                            if (ind_hit && ind_sl != 4'hf)
                                phy_reg[ind_sl[2:0]] <=
                                    {sh[14:0], mdio_s};
                            else if (ext_ok)
                                ext_reg[ext_ad] <=
                                    {sh[6:0], mdio_s};
                        end else if (std_hit)
                            phy_reg[std_sl[2:0]] <= {sh[14:0], mdio_s};
                    end
                end
                default: begin
                    // return to the preamble hunt at once, count cleared
                    // the rest of a refused frame may look like preamble
                    // ones; a real frame still needs 32 of them first
                    state     <= S_PRE;
                    cnt       <= 6'd0;
                    busy      <= 1'b0;
                    mdio_oe_b <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** hw/mras_sync.v ***
// two-stage synchroniser plus rising edge detect of the synced level
// assumes din is asynchronous to mclk
`default_nettype none
module mras_sync (
    input  wire mclk,
    input  wire rst_b,
    input  wire din,
    output reg  dout,
    output reg  rise
);
    reg s1;    // first stage, read only by s2
    reg s2;    // second stage
    // shift chain; edge is found after the second stage only
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            // both pins idle high; resetting to that level avoids a
            // false rising edge right after reset
            s1   <= 1'b1;
            s2   <= 1'b1;
            dout <= 1'b1;
            rise <= 1'b0;
        end else begin
            s1   <= din;
            s2   <= s1;
            dout <= s2;
            rise <= s2 & ~dout;
        end
    end
endmodule
`default_nettype wire

// *** verification/mras_slave_bench.sv ***
// self-checking bench: slave against the station model
// assumes the data line pulls up when nobody drives it
`default_nettype none
module mras_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] PA = 5'h01; // arbitrary station address
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        mdc, drv, mdio_out, mdio_oe_b, busy, t, b;
    logic [15:0] q, d, mem [8];
    logic [7:0]  a;
    logic [4:0]  regs [8] = '{5'h00, 5'h01, 5'h02, 5'h03,
                              5'h04, 5'h05, 5'h1d, 5'h1f};
    int          fails = 0;
    int          compares = 0;
    wire         mdio = mdio_oe_b ? drv : mdio_out; // resolved line
    always #2 mclk = ~mclk;
    mras_slave #(.PHY_ADDR(PA)) uut (.mclk(mclk), .rst_b(rst_b), .mdc(mdc),
        .mdio_in(mdio), .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b),
        .busy(busy));
    mras_station st (.mclk(mclk), .mdio(mdio), .mdc(mdc), .drv(drv));
    task automatic chk(input string n, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // extended config reads carry only the low byte
    function automatic logic [15:0] ext_rd(input logic [15:0] w);
        return {8'h00, w[7:0]};
    endfunction
    task automatic finish_test();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h49fe467d));
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        // fill every mapped register, then read back directly and indirectly
        foreach (regs[i]) begin
            mem[i] = 16'($urandom);
            st.xfer(2'b01, {PA, regs[i]}, mem[i], 1'b0, q, t);
        end
        foreach (regs[i]) begin
            st.xfer(2'b10, {PA, regs[i]}, 16'h0000, 1'b1, q, t);
            chk("std_rd", mem[i], q);
            chk("ta_bit", 16'h0000, {15'h0000, t});
            st.xfer(2'b00, {6'h3d, regs[i][3:0]}, 16'h0000, 1'b1, q, t);
            chk("ind_rd", mem[i], q);
        end
        // random extended pairs, both ends of the range first
        for (int k = 0; k < 14; k++) begin
            a = k == 0 ? 8'h00 : k == 1 ? 8'hc6 : 8'($urandom_range(198));
            d = 16'($urandom);
            b = 1'($urandom);
            st.xfer(2'b00, {1'b0, b, a}, d, 1'b0, q, t);
            st.xfer(2'b00, {1'b1, !b, a}, 16'h0000, 1'b1, q, t);
            chk("ext_rd", ext_rd(d), q);
        end
        // just past the config store: the write is dropped, reads zero
        st.xfer(2'b00, {2'b00, 8'hc7}, 16'hffff, 1'b0, q, t);
        st.xfer(2'b00, {2'b10, 8'hc7}, 16'h0000, 1'b1, q, t);
        chk("ext_gap", 16'h0000, q);
        // wrong station address: nobody answers, the pull-up reads ones
        st.xfer(2'b10, {PA ^ 5'h01, 5'h00}, 16'h0000, 1'b1, q, t);
        chk("no_answer", 16'hffff, q);
        finish_test();
    end
    // hang guard, about three times the expected run
    initial begin
        #300us;
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire

// *** verification/mras_slave_monitor.sv ***
// pin checker for the management slave
// assumes bind onto mras_slave, mdc seen directly by mclk
`default_nettype none
module mras_slave_monitor (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_b,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and reset are given once
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_idle_released: assert property (!busy |-> mdio_oe_b)
        else $error("line driven outside a frame");
    a_drive_in_frame: assert property (!mdio_oe_b |-> busy)
        else $error("drive without busy");
    a_released_high: assert property (mdio_oe_b |-> mdio_out)
        else $error("released output not high");
    a_ta_zero: assert property ($fell(mdio_oe_b) |-> !mdio_out)
        else $error("turnaround bit not zero");
    a_whole_bit: assert property ($fell(mdio_oe_b) |-> !mdio_oe_b[*8])
        else $error("drive shorter than a bit");
    a_header_listen: assert property ($rose(busy) |-> mdio_oe_b[*8])
        else $error("drive during the header");
    a_change_after_rise: assert property (
        !mdio_oe_b && $changed(mdio_out) |-> $past(mdc, 3) || $past(mdc, 4))
        else $error("data changed away from a rising edge");
    a_end_released: assert property ($fell(busy) |-> mdio_oe_b)
        else $error("still driving at frame end");
endmodule
bind mras_slave mras_slave_monitor mon (.mclk(mclk), .rst_b(rst_b),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_b(mdio_oe_b), .busy(busy));
`default_nettype wire

// *** verification/mras_station.sv ***
// management station model: makes mdc and drives the data line
// assumes a pull-up, so driving one equals releasing the line
`default_nettype none
module mras_station (
    input  wire logic mclk,
    input  wire logic mdio,
    output var  logic mdc = 1'b1,
    output var  logic drv = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    // one bit: low half then rise; 32 ns period, above the clock limit
    task automatic bit_cyc(input logic b, output logic s);
        repeat (4) @(negedge mclk);
        mdc = 1'b0;
        drv = b;
        repeat (4) @(negedge mclk);
        mdc = 1'b1;
        s = mdio;
    endtask
    // whole frame; mdc stands high between frames
    task automatic xfer(input logic [1:0] op, input logic [9:0] ad,
                        input logic [15:0] wd, input logic rd,
                        output logic [15:0] q, output logic ta);
        logic [63:0] f;
        logic        s;
        f = {32'hffffffff, 2'b01, op, ad, 2'b10, wd};
        if (rd)
            f[17:0] = '1;
        for (int i = 63; i >= 0; i--) begin
            bit_cyc(f[i], s);
            q[i % 16] = s;
            if (i == 16)
                ta = s;
        end
        // hold past the last rise, then let the pull-up take over
        repeat (4) @(negedge mclk);
        drv = 1'b1;
    endtask
endmodule
`default_nettype wire
